// file: dv/plc_scan_cycle_sequencer_test.sv
/*
  self-checking bench: init, run cycle with interrupts and service, stop.
  assumes the sequencer package and the bus model.
*/
`timescale 1ns/100ps
`default_nettype none
module plc_scan_cycle_sequencer_test;
  import pss_pkg::*;
  logic core_clk = 0, srst = 1, run_pin = 1, card_pin = 1, clr_on_run_cfg = 1;
  logic retain_out_cfg = 0, job_ok = 1, copy_wanted = 0, insn_done = 0, end_done = 0;
  logic isr_ret = 0, tmr_evt = 0, cond_lvl = 0, ext_req = 0, cpu_req = 0;
  logic comm_done = 0, slow = 0;
  logic [15:0] next_pc = 16'h0000, resume_pc, pc_seen;
  pss_state_t job_code;
  pss_dir_t io_dir;
  pss_class_t io_class;
  pss_area_t io_area;
  pss_src_t irq_src, src_seen;
  logic job_start, job_done, nlat_clear, fault, io_req, io_ack, out_off, exec_en;
  logic irq_enter, resume, comm_grant, comm_apply;
  logic saw_irq = 0, saw_res = 0, saw_nlat = 0, saw_exec = 0, saw_apply = 0;
  logic [3:0] st_q[$];
  logic [2:0] io_q[$];
  int n_mismatch = 0, n_checks = 0;
  pss_scan_seq #(.PERIODIC_CYC(100)) uut (.*);
  pss_bus_model bus (.*);
  initial forever #20 core_clk = ~core_clk;
  // monitor: state trail, answered units, sticky pulse flags
  always @(posedge core_clk) begin
    if (st_q.size() == 0 || st_q[$] !== job_code) st_q.push_back(job_code);
    if (io_req && io_ack) io_q.push_back({io_dir, io_class});
    if (irq_enter) begin saw_irq = 1; src_seen = irq_src; end
    if (resume) begin saw_res = 1; pc_seen = resume_pc; end
    if (nlat_clear) saw_nlat = 1;
    if (exec_en) saw_exec = 1;
    if (comm_apply) saw_apply = 1;
  end
  task automatic check(input string what, input logic [19:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) begin @(posedge core_clk); #1; end
  endtask
  task automatic pulse(ref logic s);
    s = 1; step(1); s = 0;
  endtask
  task automatic wait_st(input pss_state_t s);
    for (int i = 0; i < 400 && job_code !== s; i++) step(1);
    check("state reached", job_code, s);
  endtask
  // one refresh pass: digital, analog, other in the given direction
  task automatic chk_pass(input logic d);
    for (int i = 0; i < 3; i++) check("io unit", io_q[i], {d, 2'(i)});
    io_q.delete();
  endtask
  task automatic do_irq(input pss_src_t s, input logic [15:0] pc);
    saw_irq = 0; saw_res = 0;
    if (s == PSS_I_TIMER) pulse(tmr_evt);
    if (s == PSS_I_COND) cond_lvl = 1;
    step(2); next_pc = pc; pulse(insn_done); step(2);
    check("irq source", {saw_irq, src_seen}, {1'b1, s});
    pulse(isr_ret); step(2);
    check("resume pc", {saw_res, pc_seen}, {1'b1, pc});
    cond_lvl = 0;
  endtask
  task automatic t_init;
    pss_state_t e[6] = '{PSS_S_INIT_CLR, PSS_S_INIT_CHK, PSS_S_INIT_CMP, PSS_S_INIT_DL,
      PSS_S_INIT_COPY, PSS_S_DIAG};
    wait_st(PSS_S_DIAG); step(1);
    for (int i = 0; i < 6; i++) check("init order", st_q[i], e[i]);
    check("init clear", saw_nlat, 1);
    $display("test init done");
  endtask
  task t_cycle;
    wait_st(PSS_S_PROG);
    chk_pass(PSS_D_OUT);
    check("exec", exec_en, 1);
    step(110);
    do_irq(PSS_I_PERIODIC, 16'h0042);
    do_irq(PSS_I_TIMER, 16'h1234);
    do_irq(PSS_I_COND, 16'hFFFF);
    pulse(ext_req); pulse(cpu_req); step(3);
    check("early apply", saw_apply, 0);
    pulse(end_done); run_pin = 0;
    wait_st(PSS_S_COMM);
    chk_pass(PSS_D_IN);
    step(2);
    check("grant ext", {comm_grant, comm_apply}, 2'h3);
    pulse(comm_done); step(2);
    check("grant cpu", comm_grant, 1);
    pulse(comm_done);
    wait_st(PSS_S_DIAG);
    check("after comm", st_q[$], PSS_S_COMM);
    $display("test cycle done");
  endtask
  task t_stop;
    slow = 1; saw_exec = 0; io_q.delete();
    wait_st(PSS_S_IN_RFR);
    run_pin = 1; saw_nlat = 0;
    wait_st(PSS_S_COMM); step(1);
    check("stop exec", saw_exec, 0);
    check("stop units", io_q.size(), 6);
    check("stop out", out_off, 1);
    wait_st(PSS_S_PROG);
    check("run clear", saw_nlat, 1);
    check("run out", {exec_en, out_off}, 2'h2);
    pulse(end_done);
    wait_st(PSS_S_DIAG);
    $display("test stop done");
  endtask
  // failed diagnosis halts the unit; retained outputs stay on
  task t_fault;
    retain_out_cfg = 1; job_ok = 0;
    wait_st(PSS_S_FAULT); step(2);
    check("fault out", {fault, out_off}, 2'h2);
    $display("test fault done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    step(3); srst = 0; st_q.delete();
    t_init; t_cycle; t_stop; t_fault;
    finish_test;
  end
  initial begin
    #200000;
    n_mismatch++;
    finish_test;
  end
endmodule
`default_nettype wire

// file: dv/pss_bus_model.sv
/*
  far side: I/O modules answering refresh requests, and the job engine.
  assumes requests are held until acknowledged.
*/
`timescale 1ns/100ps
`default_nettype none
module pss_bus_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic io_req,
  input wire logic job_start,
  output logic io_ack = 1'b0,
  output logic job_done = 1'b0
);
  logic [2:0] wait_r = 3'h0; // cycles waited on the current unit
  // answer each unit once, promptly or after a few cycles
  always @(posedge core_clk) begin
    io_ack <= 1'b0;
    // no answer to a start seen while reset is held
    job_done <= job_start && !srst;
    if (io_req && !io_ack) begin
      wait_r <= wait_r + 3'h1;
      if (wait_r >= (slow ? 3'h4 : 3'h0)) begin
        io_ack <= 1'b1;
        wait_r <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/pss_scan_seq_assertions.sv
/*
  port checker of the scan sequencer: refresh order, phases, interrupts.
  assumes binding to pss_scan_seq, all on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pss_scan_seq_assertions
  import pss_pkg::*;
#(
  parameter int PERIODIC_CYC = 25000
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire pss_state_t job_code,
  input wire logic job_start,
  input wire logic io_req,
  input wire pss_dir_t io_dir,
  input wire pss_class_t io_class,
  input wire pss_area_t io_area,
  input wire logic io_ack,
  input wire logic exec_en,
  input wire logic insn_done,
  input wire logic irq_enter,
  input wire pss_src_t irq_src,
  input wire logic comm_grant,
  input wire logic comm_apply,
  input wire logic comm_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // leaving the service step
  sequence s_comm_exit;
    job_code == PSS_S_COMM ##1 job_code != PSS_S_COMM;
  endsequence
  // digital unit answered
  sequence s_dig_ack;
    io_req && io_ack && io_class == PSS_C_DIGITAL;
  endsequence
  chk_req_hold: assert property (io_req && !io_ack |=> io_req && $stable(io_class))
    else $error("io request dropped or changed before ack");
  chk_dig_next: assert property (s_dig_ack |-> ##[1:2] (io_req && io_class == PSS_C_ANALOG))
    else $error("analog unit does not follow digital");
  chk_area_map: assert property (io_req |->
    io_area == (io_class == PSS_C_DIGITAL ? PSS_A_RELAY : PSS_A_DREG))
    else $error("wrong exchange area for class");
  chk_dir_phase: assert property (io_req |->
    io_dir == (job_code == PSS_S_OUT_RFR ? PSS_D_OUT : PSS_D_IN))
    else $error("refresh direction does not match phase");
  chk_exec_phase: assert property (exec_en |-> job_code == PSS_S_PROG)
    else $error("program enabled outside program phase");
  chk_irq_boundary: assert property (irq_enter |-> $past(insn_done) && irq_src != PSS_I_NONE)
    else $error("interrupt entered off an instruction boundary");
  chk_apply_grant: assert property (comm_apply |-> comm_grant)
    else $error("update applied without service grant");
  chk_grant_hold: assert property (comm_grant && !comm_done |=> comm_grant)
    else $error("service grant dropped early");
  chk_comm_diag: assert property (s_comm_exit |-> job_code == PSS_S_DIAG)
    else $error("service step not followed by diagnosis");
  chk_diag_job: assert property (job_code == PSS_S_DIAG && $past(job_code) != PSS_S_DIAG
    |-> ##[0:1] job_start)
    else $error("diagnosis entered without starting its job");
endmodule
bind pss_scan_seq pss_scan_seq_assertions #(.PERIODIC_CYC(PERIODIC_CYC)) u_chk (.*);
`default_nettype wire

// file: rtl/pss_io_refresh.sv
/*
  refresh engine: walks digital, analog, other module classes on the I/O bus.
  assumes the bus answers every request with io_ack eventually.
*/
`timescale 1ns/100ps
`default_nettype none
module pss_io_refresh
  import pss_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  srst,
  pss_rfr_if.eng     rfr,
  output logic       io_req,
  output pss_dir_t   io_dir,
  output pss_class_t io_class,
  output pss_area_t  io_area,
  input  wire logic  io_ack
);
  logic       busy_r, busy_nxt;   // pass in progress
  pss_class_t cls_r, cls_nxt;     // class now served
  pss_dir_t   dir_r, dir_nxt;     // latched direction
  logic       done_r, done_nxt;   // end-of-pass pulse

  // ----------------------------------------------------------------------
  // class walk
  // ----------------------------------------------------------------------
  always_comb begin
    busy_nxt = busy_r;
    cls_nxt  = cls_r;
    dir_nxt  = dir_r;
    done_nxt = 1'b0;
    if (!busy_r && rfr.start) begin
      // digital first, then analog, then the rest
      busy_nxt = 1'b1; // RULE5 RULE6
      cls_nxt  = PSS_C_DIGITAL;
      dir_nxt  = rfr.dir;
    end else if (busy_r && io_ack) begin
      if (cls_r == PSS_C_OTHER) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cls_nxt = pss_class_t'(cls_r + 2'h1);
      end
    end
  end

  // registers of the walk
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      cls_r  <= PSS_C_DIGITAL;
      dir_r  <= PSS_D_IN;
      done_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      cls_r  <= cls_nxt;
      dir_r  <= dir_nxt;
      done_r <= done_nxt;
    end
  end

  assign io_req   = busy_r;
  assign io_dir   = dir_r;
  assign io_class = cls_r;
  // digital units use the relay areas, all others the data registers
  assign io_area  = (cls_r == PSS_C_DIGITAL) ? PSS_A_RELAY : PSS_A_DREG; // RULE8
  assign rfr.done = done_r;
endmodule
`default_nettype wire

// file: rtl/pss_irq_ctl.sv
/*
  interrupt control: periodic, timer and condition sources, entry at
  instruction boundaries, saved resume position.
  assumes insn_done pulses once per completed instruction.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pss_regs.svh"
module pss_irq_ctl
  import pss_pkg::*;
#(
  parameter int PERIODIC_CYC = `PSS_PERIODIC_CYC,
  parameter int PC_W         = `PSS_PC_W
) (
  input  wire logic            core_clk,
  input  wire logic            srst,
  input  wire logic            enable,
  input  wire logic            tmr_evt,
  input  wire logic            cond_lvl,
  input  wire logic            insn_done,
  input  wire logic [PC_W-1:0] next_pc,
  input  wire logic            isr_ret,
  output logic                 irq_enter,
  output pss_src_t             irq_src,
  output logic                 irq_busy,
  output logic      [PC_W-1:0] resume_pc,
  output logic                 resume
);
  logic [31:0]     per_cnt_r, per_cnt_nxt; // periodic divider
  logic [2:0]      pend_r, pend_nxt;       // pending: cond, timer, periodic
  logic            busy_r, busy_nxt;       // routine in service
  pss_src_t        src_r, src_nxt;         // source in service
  logic [PC_W-1:0] pc_r, pc_nxt;           // saved next-instruction position
  logic            ent_r, ent_nxt;         // entry pulse
  logic            res_r, res_nxt;         // resume pulse
  logic            cond_d_r, cond_d_nxt;   // condition level delayed
  logic [2:0]      evt;                    // new events this cycle
  logic            take;                   // entry accepted

  // ----------------------------------------------------------------------
  // pending, entry and return
  // ----------------------------------------------------------------------
  always_comb begin
    per_cnt_nxt = per_cnt_r + 32'h1;
    evt         = 3'h0;
    if (per_cnt_r >= 32'(PERIODIC_CYC - 1)) begin
      per_cnt_nxt = 32'h0;
      evt[0]      = enable;
    end
    evt[1]     = tmr_evt & enable;
    evt[2]     = cond_lvl & ~cond_d_r & enable; // RULE11
    cond_d_nxt = cond_lvl;
    take       = enable && !busy_r && insn_done && (pend_r != 3'h0); // RULE12
    pend_nxt   = pend_r;
    busy_nxt   = busy_r;
    src_nxt    = src_r;
    pc_nxt     = pc_r;
    ent_nxt    = 1'b0;
    res_nxt    = 1'b0;
    if (take) begin
      // periodic first, then timer, then condition
      busy_nxt = 1'b1;
      ent_nxt  = 1'b1;
      pc_nxt   = next_pc; // RULE12
      if (pend_r[0]) begin
        src_nxt     = PSS_I_PERIODIC;
        pend_nxt[0] = 1'b0;
      end else if (pend_r[1]) begin
        src_nxt     = PSS_I_TIMER;
        pend_nxt[1] = 1'b0;
      end else begin
        src_nxt     = PSS_I_COND;
        pend_nxt[2] = 1'b0;
      end
    end else if (busy_r && isr_ret) begin
      busy_nxt = 1'b0;
      res_nxt  = 1'b1; // RULE13
      src_nxt  = PSS_I_NONE;
    end
    // new events win over the clear
    pend_nxt = pend_nxt | evt;
    if (!enable) begin
      pend_nxt = 3'h0; // RULE14
    end
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      per_cnt_r <= 32'h0;
      pend_r    <= 3'h0;
      busy_r    <= 1'b0;
      src_r     <= PSS_I_NONE;
      pc_r      <= PC_W'(`PSS_PC_RST);
      ent_r     <= 1'b0;
      res_r     <= 1'b0;
      cond_d_r  <= 1'b0;
    end else begin
      per_cnt_r <= per_cnt_nxt;
      pend_r    <= pend_nxt;
      busy_r    <= busy_nxt;
      src_r     <= src_nxt;
      pc_r      <= pc_nxt;
      ent_r     <= ent_nxt;
      res_r     <= res_nxt;
      cond_d_r  <= cond_d_nxt;
    end
  end

  assign irq_enter = ent_r;
  assign irq_src   = src_r;
  assign irq_busy  = busy_r;
  assign resume_pc = pc_r;
  assign resume    = res_r;
endmodule
`default_nettype wire

// file: rtl/pss_pkg.sv
/*
  types of the scan cycle sequencer: states, module classes, directions,
  interrupt sources.
  assumes pss_regs.svh is on the include path.
*/
package pss_pkg;
  // ----------------------------------------------------------------------
  // main sequence states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    PSS_S_INIT_CLR  = 4'h0,
    PSS_S_INIT_CHK  = 4'h1,
    PSS_S_INIT_CMP  = 4'h2,
    PSS_S_INIT_DL   = 4'h3,
    PSS_S_INIT_COPY = 4'h4,
    PSS_S_DIAG      = 4'h5,
    PSS_S_OUT_RFR   = 4'h6,
    PSS_S_PROG      = 4'h7,
    PSS_S_IN_RFR    = 4'h8,
    PSS_S_COMM      = 4'h9,
    PSS_S_FAULT     = 4'hA
  } pss_state_t;

  // module classes in refresh order
  typedef enum logic [1:0] {
    PSS_C_DIGITAL = 2'h0,
    PSS_C_ANALOG  = 2'h1,
    PSS_C_OTHER   = 2'h2
  } pss_class_t;

  // refresh direction
  typedef enum logic {
    PSS_D_IN  = 1'h0,
    PSS_D_OUT = 1'h1
  } pss_dir_t;

  // data exchange area
  typedef enum logic {
    PSS_A_RELAY = 1'h0,
    PSS_A_DREG  = 1'h1
  } pss_area_t;

  // interrupt sources
  typedef enum logic [1:0] {
    PSS_I_NONE     = 2'h0,
    PSS_I_PERIODIC = 2'h1,
    PSS_I_TIMER    = 2'h2,
    PSS_I_COND     = 2'h3
  } pss_src_t;
endpackage

// file: rtl/pss_regs.svh
/*
  constants of the scan cycle sequencer: field widths, reset values and timing counts.
  assumes it is included by bare name from the sequencer and interrupt modules.
*/
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define PSS_CLK_KHZ        25000
`define PSS_PERIODIC_US    1000
`define PSS_PERIODIC_CYC   ((`PSS_PERIODIC_US * `PSS_CLK_KHZ) / 1000)

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define PSS_PC_W           16
`define PSS_PC_RST         16'h0000
`define PSS_CLASS_W        2
`define PSS_SRC_W          2

`endif

// file: rtl/pss_rfr_if.sv
/*
  carrier between the sequencer and its refresh engine.
  assumes both ends run on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface pss_rfr_if;
  import pss_pkg::*;
  logic     start;  // one-cycle pulse: begin a refresh pass
  pss_dir_t dir;    // pass direction
  logic     done;   // one-cycle pulse: pass finished
  // ----------------------------------------------------------------------
  // views
  // ----------------------------------------------------------------------
  modport seq (output start, output dir, input done);
  modport eng (input start, input dir, output done);
endinterface
`default_nettype wire

// file: rtl/pss_scan_seq.sv
/*
  scan cycle sequencer: power-up initialization, then the endless loop of
  diagnosis, output refresh, program, input refresh, communication service.
  assumes an external job engine does the checks it is started for, and an
  instruction engine reports completed instructions and the end instruction.
*/
//
// Behaviour
// [RULE1] init clears volatile memory, checks program, parameters
// [RULE2] init compares module table, downloads I/O settings
// [RULE3] with card present, evaluate system copy first
// [RULE4] each cycle starts with diagnosis
// [RULE5] output refresh: digital, analog, then others
// [RULE6] program with interrupts, then input refresh
// [RULE7] all refresh in one loop around program
// [RULE8] digital uses relays, others data registers
// [RULE9] last step serves communication both directions
// [RULE10] internal updates applied only after end instruction
// [RULE11] periodic, timer and condition interrupt sources
// [RULE12] enter interrupt at boundary, save next position
// [RULE13] resume at saved next instruction
// [RULE14] stopped: skip program and tasks, keep refresh
// [RULE15] stopped: outputs off unless retain configured
// [RULE16] stop-to-run clears volatile memory per setting
// [RULE17] after communication go straight to diagnosis
`timescale 1ns/100ps
`default_nettype none
`include "pss_regs.svh"
module pss_scan_seq
  import pss_pkg::*;
#(
  parameter int PERIODIC_CYC = `PSS_PERIODIC_CYC,
  parameter int PC_W         = `PSS_PC_W
) (
  input  wire logic            core_clk,
  input  wire logic            srst,
  // mode and straps from pins
  input  wire logic            run_pin,
  input  wire logic            card_pin,
  input  wire logic            clr_on_run_cfg,
  input  wire logic            retain_out_cfg,
  // job engine handshake
  output pss_state_t           job_code,
  output logic                 job_start,
  input  wire logic            job_done,
  input  wire logic            job_ok,
  input  wire logic            copy_wanted,
  output logic                 nlat_clear,
  output logic                 fault,
  // I/O bus
  output logic                 io_req,
  output pss_dir_t             io_dir,
  output pss_class_t           io_class,
  output pss_area_t            io_area,
  input  wire logic            io_ack,
  output logic                 out_off,
  // program engine
  output logic                 exec_en,
  input  wire logic            insn_done,
  input  wire logic [PC_W-1:0] next_pc,
  input  wire logic            end_done,
  input  wire logic            isr_ret,
  input  wire logic            tmr_evt,
  input  wire logic            cond_lvl,
  output logic                 irq_enter,
  output pss_src_t             irq_src,
  output logic      [PC_W-1:0] resume_pc,
  output logic                 resume,
  // communication service
  input  wire logic            ext_req,
  input  wire logic            cpu_req,
  output logic                 comm_grant,
  output logic                 comm_apply,
  input  wire logic            comm_done
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic       run_s1_r, run_s2_r;      // run pin synchroniser
  logic       card_s1_r, card_s2_r;    // card pin synchroniser
  pss_state_t st_r, st_nxt;            // sequence state
  logic       go_r, go_nxt;            // first cycle of a state
  logic       run_r, run_nxt;          // mode frozen for this cycle
  logic       clr_r, clr_nxt;          // volatile clear pulse
  logic       end_seen_r, end_seen_nxt; // end instruction executed
  logic       ext_p_r, ext_p_nxt;      // pending request from outside
  logic       cpu_p_r, cpu_p_nxt;      // pending request from the cpu
  logic       grant_r, grant_nxt;      // service in progress
  logic       flt_r, flt_nxt;          // fault latch
  logic       off_r, off_nxt;          // external outputs forced off
  logic       irq_busy;                // routine in service
  logic       prog_en;                 // program phase and running
  pss_rfr_if  rfr ();                  // link to refresh engine

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // two flops per pin, the first read only by the second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_s1_r  <= 1'b0;
      run_s2_r  <= 1'b0;
      card_s1_r <= 1'b0;
      card_s2_r <= 1'b0;
    end else begin
      run_s1_r  <= run_pin;
      run_s2_r  <= run_s1_r;
      card_s1_r <= card_pin;
      card_s2_r <= card_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  // next state, mode freeze and clear pulse
  always_comb begin
    st_nxt    = st_r;
    run_nxt   = run_r;
    clr_nxt   = 1'b0;
    flt_nxt   = flt_r;
    rfr.start = 1'b0;
    rfr.dir   = PSS_D_OUT;
    case (st_r)
      PSS_S_INIT_CLR: begin
        // volatile memory wiped once after power-up
        clr_nxt = go_r; // RULE1
        if (job_done) begin
          st_nxt = PSS_S_INIT_CHK;
        end
      end
      PSS_S_INIT_CHK: begin
        // program, cpu and table parameters checked
        if (job_done) begin
          st_nxt = job_ok ? PSS_S_INIT_CMP : PSS_S_FAULT; // RULE1
        end
      end
      PSS_S_INIT_CMP: begin
        // stored table against the fitted modules
        if (job_done) begin
          st_nxt = job_ok ? PSS_S_INIT_DL : PSS_S_FAULT; // RULE2
        end
      end
      PSS_S_INIT_DL: begin
        // settings sent to each module, then card check
        if (job_done) begin
          st_nxt = card_s2_r ? PSS_S_INIT_COPY : PSS_S_DIAG; // RULE2 RULE3
        end
      end
      PSS_S_INIT_COPY: begin
        // copy evaluated; a wanted copy that fails stops the unit
        if (job_done) begin
          st_nxt = (copy_wanted && !job_ok) ? PSS_S_FAULT : PSS_S_DIAG; // RULE3
        end
      end
      PSS_S_DIAG: begin
        // mode sampled once per cycle at its head
        if (go_r) begin
          run_nxt = run_s2_r;
          clr_nxt = run_s2_r && !run_r && clr_on_run_cfg; // RULE16
        end
        if (job_done) begin
          st_nxt    = job_ok ? PSS_S_OUT_RFR : PSS_S_FAULT; // RULE4
          rfr.start = job_ok;
          rfr.dir   = PSS_D_OUT; // RULE7
        end
      end
      PSS_S_OUT_RFR: begin
        // outputs leave after the previous program pass
        if (rfr.done) begin
          st_nxt = PSS_S_PROG; // RULE5
        end
      end
      PSS_S_PROG: begin
        // skipped when stopped; leaves on end outside a routine
        if (!run_r || (end_done && !irq_busy)) begin
          st_nxt    = PSS_S_IN_RFR; // RULE6 RULE14
          rfr.start = 1'b1;
          rfr.dir   = PSS_D_IN; // RULE7
        end
      end
      PSS_S_IN_RFR: begin
        // inputs come in before the next program pass
        if (rfr.done) begin
          st_nxt = PSS_S_COMM; // RULE6
        end
      end
      PSS_S_COMM: begin
        // served until nothing pending, then next cycle
        if (!ext_p_r && !cpu_p_r) begin
          st_nxt = PSS_S_DIAG; // RULE17
        end
      end
      PSS_S_FAULT: begin
        // held until reset
        flt_nxt = 1'b1;
      end
      default: begin
        st_nxt = PSS_S_FAULT;
      end
    endcase
    go_nxt = (st_nxt != st_r);
  end

  // registers of the sequence
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r  <= PSS_S_INIT_CLR;
      go_r  <= 1'b1;
      run_r <= 1'b0;
      clr_r <= 1'b0;
      flt_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      go_r  <= go_nxt;
      run_r <= run_nxt;
      clr_r <= clr_nxt;
      flt_r <= flt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // communication service
  // ----------------------------------------------------------------------
  // requests latched at any time, served in the last step
  always_comb begin
    ext_p_nxt    = ext_p_r;
    cpu_p_nxt    = cpu_p_r;
    grant_nxt    = grant_r;
    end_seen_nxt = end_seen_r;
    if (st_r == PSS_S_PROG && end_done) begin
      end_seen_nxt = 1'b1; // RULE10
    end
    if (st_r == PSS_S_COMM) begin
      if (!grant_r && (ext_p_r || cpu_p_r)) begin
        grant_nxt = 1'b1; // RULE9
      end else if (grant_r && comm_done) begin
        // outside requests first, then the cpu's own
        grant_nxt = 1'b0;
        if (ext_p_r) begin
          ext_p_nxt = 1'b0;
        end else begin
          cpu_p_nxt = 1'b0;
        end
      end
    end
    if (st_r == PSS_S_DIAG) begin
      end_seen_nxt = 1'b0;
    end
    // a request in the clearing cycle is kept
    ext_p_nxt = ext_p_nxt | ext_req; // RULE9
    cpu_p_nxt = cpu_p_nxt | cpu_req;
  end

  // registers of the service
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_p_r    <= 1'b0;
      cpu_p_r    <= 1'b0;
      grant_r    <= 1'b0;
      end_seen_r <= 1'b0;
    end else begin
      ext_p_r    <= ext_p_nxt;
      cpu_p_r    <= cpu_p_nxt;
      grant_r    <= grant_nxt;
      end_seen_r <= end_seen_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // output state
  // ----------------------------------------------------------------------
  // outputs forced off while stopped or faulted unless retained
  always_comb begin
    off_nxt = (!run_nxt || flt_nxt) && !retain_out_cfg; // RULE15
  end

  // output register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      off_r <= 1'b1;
    end else begin
      off_r <= off_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------------
  assign prog_en = (st_r == PSS_S_PROG) && run_r; // RULE14

  // class walk on the I/O bus
  pss_io_refresh u_rfr (
    .core_clk (core_clk),
    .srst     (srst),
    .rfr      (rfr),
    .io_req   (io_req),
    .io_dir   (io_dir),
    .io_class (io_class),
    .io_area  (io_area),
    .io_ack   (io_ack)
  );

  // interrupt entry and return
  pss_irq_ctl #(
    .PERIODIC_CYC (PERIODIC_CYC),
    .PC_W         (PC_W)
  ) u_irq (
    .core_clk  (core_clk),
    .srst      (srst),
    .enable    (prog_en),
    .tmr_evt   (tmr_evt),
    .cond_lvl  (cond_lvl),
    .insn_done (insn_done),
    .next_pc   (next_pc),
    .isr_ret   (isr_ret),
    .irq_enter (irq_enter),
    .irq_src   (irq_src),
    .irq_busy  (irq_busy),
    .resume_pc (resume_pc),
    .resume    (resume)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign job_code   = st_r;
  assign job_start  = go_r && (st_r != PSS_S_OUT_RFR) && (st_r != PSS_S_PROG)
                      && (st_r != PSS_S_IN_RFR) && (st_r != PSS_S_COMM)
                      && (st_r != PSS_S_FAULT);
  assign nlat_clear = clr_r;
  assign fault      = flt_r;
  assign out_off    = off_r;
  assign exec_en    = prog_en;
  assign comm_grant = grant_r;
  // internal device updates only once the end instruction ran
  assign comm_apply = grant_r && end_seen_r; // RULE10
endmodule
`default_nettype wire
